// ### frbb_nvm_model.sv
`timescale 1ns/1ps
module frbb_nvm_model (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire frbb_pkg::frbb_nvm_req_t nvm_req_o,
  input wire logic slow_i,
  output logic nvm_ack_i,
  output logic [7:0] nvm_rdata_i
);
  logic [7:0] mem [0:127];
  int cnt;
  initial for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
  // read data toggles outside ack so a stale value never looks valid
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nvm_ack_i <= 1'b0;
      nvm_rdata_i <= 8'h5A;
      cnt <= 0;
    end else if (nvm_req_o.req && !nvm_ack_i && cnt >= (slow_i ? 3 : 0)) begin
      nvm_ack_i <= 1'b1;
      cnt <= 0;
      nvm_rdata_i <= mem[nvm_req_o.addr[6:0]];
      if (nvm_req_o.we) mem[nvm_req_o.addr[6:0]] <= nvm_req_o.wdata;
    end else begin
      nvm_ack_i <= 1'b0;
      nvm_rdata_i <= ~nvm_rdata_i;
      cnt <= nvm_req_o.req ? cnt + 1 : 0;
    end
  end
endmodule

// ### frbb_pkg.sv
package frbb_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] TRIG_0_7_OFS = 8'h94;
  localparam logic [7:0] TRIG_8_15_OFS = 8'h95;
  localparam logic [7:0] TRIG_16_23_OFS = 8'h96;
  localparam logic [7:0] TRIG_24_31_OFS = 8'h97;
  localparam logic [7:0] TRIG_32_39_OFS = 8'h98;
  localparam logic [7:0] TRIG_40_47_OFS = 8'h99;
  localparam logic [7:0] TRIG_48_55_OFS = 8'h9A;
  localparam logic [7:0] TRIG_56_63_OFS = 8'h9B;
  localparam logic [7:0] CONTROL_OFS = 8'h9C;
  localparam logic [7:0] SEARCH_OFS = 8'hD9;
  localparam int HALT_BIT = 0;
  localparam int SEARCH_BIT = 0;
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam logic [15:0] RECORD_BASE = 16'hF980;
  localparam int NUM_STATES = 64;
  localparam int NUM_TRIG_REGS = 8;

  // register port request from the serial bus front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } frbb_reg_req_t;

  // nonvolatile memory port, one byte per access
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } frbb_nvm_req_t;

  typedef enum logic [2:0] {
    ST_SCAN_RD,
    ST_SCAN_WAIT,
    ST_IDLE,
    ST_REC_WR,
    ST_REC_WAIT
  } frbb_state_t;
endpackage

// ### frbb_recorder.sv
`timescale 1ns/1ps
// How it works
// R1: entering a state whose trigger bit is set writes one record.
// R2: registers 0x98..0x9B hold triggers for states 32..63, bit b is 32+8i+b.
// R3: software keeps the state 63 trigger bit at zero.
// R4: recorder is enabled when any trigger bit is one.
// R5: enabled and not halted blocks software memory access.
// R6: writing 1 to control bit 0 halts recorder and restores memory access.
// R7: halt writes during a record write are dropped; software reads back.
// R8: writing 1 to search bit 0 rescans from 0xF980 for the first unused slot; the code takes it only when idle and ignores it while busy.
// R9: software issues a search after erasing the record area.
// R10: bits 7..1 of control and search are not stored and read zero.
// R11: after reset the slot scan runs by itself.
// R12: registers 0x94..0x97 hold triggers 0..31, loaded at init, writable.
// R13: software keeps triggers for states 0 and 1 at zero.
// R14: record write is one busy run; slot advances after completion.
module frbb_recorder #(
  parameter int SLOTS = 16,
  parameter int REC_BYTES = 8,
  parameter logic [7:0] ERASED = 8'hFF
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire frbb_pkg::frbb_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic cfg_load_i,
  input wire logic [31:0] cfg_trig_i,
  input wire logic [5:0] power_step_state_i,
  input wire logic [7:0] nvm_rdata_i,
  input wire logic nvm_ack_i,
  output frbb_pkg::frbb_nvm_req_t nvm_req_o,
  output logic nvm_sw_block_o,
  output logic busy_o
);
  localparam int PW = $clog2(SLOTS + 1);
  localparam int BW = $clog2(REC_BYTES);

  ////////////////////////////////////////////////////////////////////////
  logic [frbb_pkg::NUM_STATES-1:0] trig_reg, trig_next;
  logic halt_reg, halt_next;
  logic [7:0] rdata_reg, rdata_next;
  frbb_pkg::frbb_state_t st_reg, st_next;
  logic [PW-1:0] slot_reg, slot_next;
  logic [BW-1:0] byte_reg, byte_next;
  logic [5:0] prev_reg, prev_next;
  logic [5:0] cap_reg, cap_next;
  logic pend_reg, pend_next;
  frbb_pkg::frbb_nvm_req_t nvm_reg, nvm_next;
  logic block_reg, block_next;
  logic busy_reg, busy_next;
  logic enabled;
  logic hit;
  logic [2:0] widx;
  logic wtrig;

  assign enabled = |trig_reg; // [R4]
  // only the entry edge counts, so dwelling in a state records once
  assign hit = power_step_state_i != prev_reg &&
    trig_reg[power_step_state_i] && enabled && !halt_reg; // [R1]
  assign widx = 3'(reg_req_i.addr - frbb_pkg::TRIG_0_7_OFS);
  assign wtrig = reg_req_i.addr >= frbb_pkg::TRIG_0_7_OFS &&
    reg_req_i.addr <= frbb_pkg::TRIG_56_63_OFS;

  function automatic logic [15:0] slot_addr(input logic [PW-1:0] s,
                                            input logic [BW-1:0] b);
    slot_addr = 16'(frbb_pkg::RECORD_BASE + s * REC_BYTES + b);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    trig_next = trig_reg;
    halt_next = halt_reg;
    rdata_next = rdata_reg;
    if (cfg_load_i) begin
      trig_next[31:0] = cfg_trig_i; // [R12]
    end
    if (reg_req_i.wr && wtrig) begin
      trig_next[widx*8 +: 8] = reg_req_i.wdata; // [R2] [R12]
    end
    // a halt request is dropped while a record is in flight
    if (reg_req_i.wr && reg_req_i.addr == frbb_pkg::CONTROL_OFS &&
        st_reg != frbb_pkg::ST_REC_WR && st_reg != frbb_pkg::ST_REC_WAIT) begin
      halt_next = reg_req_i.wdata[frbb_pkg::HALT_BIT]; // [R6] [R7] [R14]
    end
    if (reg_req_i.rd) begin
      if (wtrig) begin
        rdata_next = trig_reg[widx*8 +: 8];
      end else if (reg_req_i.addr == frbb_pkg::CONTROL_OFS) begin
        rdata_next = {7'h00, halt_reg}; // [R10]
      end else if (reg_req_i.addr == frbb_pkg::SEARCH_OFS) begin
        rdata_next = 8'h00; // [R10]
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_reg <= '0;
      halt_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      trig_reg <= trig_next;
      halt_reg <= halt_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    slot_next = slot_reg;
    byte_next = byte_reg;
    cap_next = cap_reg;
    nvm_next = nvm_reg;
    prev_next = power_step_state_i;
    pend_next = pend_reg;
    // state entry seen while scanning or writing is kept for later
    // limitation: only one entry is queued, a later one overwrites it
    if (hit) begin
      pend_next = 1'b1; // [R1]
      cap_next = power_step_state_i;
    end
    block_next = enabled && !halt_reg; // [R5]
    case (st_reg)
      frbb_pkg::ST_SCAN_RD: begin
        if (slot_reg == PW'(SLOTS)) begin
          st_next = frbb_pkg::ST_IDLE; // area full: no more records
        end else begin
          nvm_next = '{req: 1'b1, we: 1'b0, addr: slot_addr(slot_reg, '0),
                       wdata: 8'h00};
          st_next = frbb_pkg::ST_SCAN_WAIT;
        end
      end
      frbb_pkg::ST_SCAN_WAIT: begin
        if (nvm_ack_i) begin
          nvm_next.req = 1'b0;
          if (nvm_rdata_i == ERASED) begin
            st_next = frbb_pkg::ST_IDLE; // [R8] [R11]
          end else begin
            slot_next = slot_reg + PW'(1);
            st_next = frbb_pkg::ST_SCAN_RD;
          end
        end
      end
      frbb_pkg::ST_IDLE: begin
        // search is taken only when idle, so a scan never cuts a record
        if (reg_req_i.wr && reg_req_i.addr == frbb_pkg::SEARCH_OFS &&
            reg_req_i.wdata[frbb_pkg::SEARCH_BIT]) begin
          slot_next = '0; // [R8]
          st_next = frbb_pkg::ST_SCAN_RD;
        end else if (pend_reg && slot_reg != PW'(SLOTS)) begin
          // an entry arriving in this very cycle must not be lost
          pend_next = hit;
          byte_next = '0;
          st_next = frbb_pkg::ST_REC_WR; // [R14]
        end
      end
      frbb_pkg::ST_REC_WR: begin
        // byte 0 holds the state, the rest its record index
        nvm_next = '{req: 1'b1, we: 1'b1, addr: slot_addr(slot_reg, byte_reg),
                     wdata: (byte_reg == '0) ? {2'b00, cap_reg} :
                       8'(slot_reg)};
        st_next = frbb_pkg::ST_REC_WAIT;
      end
      frbb_pkg::ST_REC_WAIT: begin
        if (nvm_ack_i) begin
          nvm_next.req = 1'b0;
          if (byte_reg == BW'(REC_BYTES - 1)) begin
            slot_next = slot_reg + PW'(1); // [R14]
            st_next = frbb_pkg::ST_IDLE;
          end else begin
            byte_next = byte_reg + BW'(1);
            st_next = frbb_pkg::ST_REC_WR;
          end
        end
      end
      default: st_next = frbb_pkg::ST_IDLE;
    endcase
    // busy follows the next state so the output stays a plain flip-flop
    busy_next = st_next != frbb_pkg::ST_IDLE; // [R14]
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= frbb_pkg::ST_SCAN_RD; // [R11]
      slot_reg <= '0;
      byte_reg <= '0;
      prev_reg <= 6'h00;
      cap_reg <= 6'h00;
      pend_reg <= 1'b0;
      nvm_reg <= '0;
      block_reg <= 1'b0;
      // the power-up scan starts at once, so busy leaves reset high
      busy_reg <= 1'b1; // [R11]
    end else begin
      st_reg <= st_next;
      slot_reg <= slot_next;
      byte_reg <= byte_next;
      prev_reg <= prev_next;
      cap_reg <= cap_next;
      pend_reg <= pend_next;
      nvm_reg <= nvm_next;
      block_reg <= block_next;
      busy_reg <= busy_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign nvm_req_o = nvm_reg;
  assign nvm_sw_block_o = block_reg;
  assign busy_o = busy_reg;
endmodule

// ### frbb_recorder_properties.sv
`timescale 1ns/1ps
module frbb_recorder_properties #(
  parameter int SLOTS = 16,
  parameter int REC_BYTES = 8
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire frbb_pkg::frbb_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic nvm_ack_i,
  input wire frbb_pkg::frbb_nvm_req_t nvm_req_o,
  input wire logic busy_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire [15:0] ofs = nvm_req_o.addr - frbb_pkg::RECORD_BASE;
  wire rq = nvm_req_o.req;
  a_req_hold: assert property (
    rq && !nvm_ack_i |=> rq && $stable(nvm_req_o))
    else $error("memory request changed before ack");
  a_req_drop: assert property (
    nvm_ack_i |=> !rq)
    else $error("memory request not dropped after ack");
  a_req_busy: assert property (
    rq |-> busy_o)
    else $error("memory access while not busy");
  a_area_addr: assert property (
    rq |-> ofs < SLOTS * REC_BYTES)
    else $error("memory access outside record area");
  a_scan_byte0: assert property (
    rq && !nvm_req_o.we |-> ofs % REC_BYTES == 0)
    else $error("scan read not at slot start");
  a_state_byte: assert property (
    rq && nvm_req_o.we && ofs % REC_BYTES == 0
    |-> nvm_req_o.wdata[7:6] == 2'b00) else $error("bad state byte");
  a_rdata_hold: assert property (
    !reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  a_ctrl_bits: assert property (
    reg_req_i.rd &&
    reg_req_i.addr == frbb_pkg::CONTROL_OFS |=> reg_rdata_o[7:1] == 7'h00)
    else $error("control upper bits not zero");
  a_search_zero: assert property (
    reg_req_i.rd &&
    reg_req_i.addr == frbb_pkg::SEARCH_OFS |=> reg_rdata_o == 8'h00)
    else $error("search register not zero");
  c_wr: cover property (rq && nvm_req_o.we && nvm_ack_i);
  c_rd: cover property (rq && !nvm_req_o.we && nvm_ack_i);
  c_hold: cover property (rq && !nvm_ack_i ##1 rq);
endmodule

// ### frbb_recorder_tb.sv
`timescale 1ns/1ps
module frbb_recorder_tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  frbb_pkg::frbb_reg_req_t reg_req_i = '0;
  logic cfg_load_i = 1'b0;
  logic [31:0] cfg_trig_i = '0;
  logic [5:0] power_step_state_i = '0;
  logic slow_i = 1'b0;
  logic [7:0] reg_rdata_o, nvm_rdata_i;
  logic nvm_ack_i, nvm_sw_block_o, busy_o;
  frbb_pkg::frbb_nvm_req_t nvm_req_o;
  logic [31:0] lfsr = 32'h06531A4D;
  logic [5:0] st;
  int err_count = 0;
  int total_checks = 0;
  initial forever #2.5 mclk_i = ~mclk_i;
  frbb_recorder u_frbb_recorder (.mclk_i, .rst_b_i, .reg_req_i, .reg_rdata_o,
    .cfg_load_i, .cfg_trig_i, .power_step_state_i, .nvm_rdata_i, .nvm_ack_i,
    .nvm_req_o, .nvm_sw_block_o, .busy_o);
  frbb_nvm_model u_frbb_nvm_model (.mclk_i, .rst_b_i, .nvm_req_o, .slow_i,
    .nvm_ack_i, .nvm_rdata_i);
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_req_i = '{w, !w, a, d};
    tick(1);
    if (!w) chk(reg_rdata_o, d);
    reg_req_i = '0;
    tick(1);
  endtask
  task automatic wait_busy();
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    if (busy_o !== 1'b1) n = 900;
    while (busy_o !== 1'b0 && n < 900) begin
      tick(1);
      n++;
    end
    if (n >= 900) begin
      err_count++;
      $display("BAD %0t busy timeout", $time);
      wrap_up();
    end
  endtask
  task automatic step();
    power_step_state_i = st ^ 6'h01;
    tick(3);
    power_step_state_i = st;
  endtask
  initial begin
    tick(16);
    rst_b_i = 1'b1;
    wait_busy();
    for (int i = 0; i < 8; i++) acc(0, 8'h94 + 8'(i), 8'h00);
    acc(0, 8'h50, 8'h00);
    acc(0, frbb_pkg::CONTROL_OFS, 8'h00);
    lfsr = lfsr_next(lfsr);
    cfg_trig_i = lfsr & 32'hFFFFFFFC; // states 0 and 1 kept clear
    cfg_load_i = 1'b1;
    tick(1);
    cfg_load_i = 1'b0;
    for (int i = 0; i < 4; i++) acc(0, 8'h94 + 8'(i), cfg_trig_i[8*i+:8]);
    st = 6'd2 + 6'(lfsr % 60); // never state 63
    acc(1, 8'h94 + 8'(st[5:3]), 8'h01 << st[2:0]);
    acc(0, 8'h94 + 8'(st[5:3]), 8'h01 << st[2:0]);
    chk({7'h00, nvm_sw_block_o}, 8'h01);
    power_step_state_i = st;
    wait_busy();
    chk(u_frbb_nvm_model.mem[0], {2'b00, st});
    power_step_state_i = st ^ 6'h01;
    tick(20);
    chk(u_frbb_nvm_model.mem[8], 8'hFF);
    slow_i = 1'b1;
    power_step_state_i = st;
    wait_busy();
    chk(u_frbb_nvm_model.mem[9], 8'h01);
    step();
    for (int n = 0; n < 9 && busy_o !== 1'b1; n++) tick(1);
    acc(1, frbb_pkg::CONTROL_OFS, 8'h01);
    wait_busy();
    acc(0, frbb_pkg::CONTROL_OFS, 8'h00);
    acc(1, frbb_pkg::CONTROL_OFS, 8'hFF);
    acc(0, frbb_pkg::CONTROL_OFS, 8'h01);
    chk({7'h00, nvm_sw_block_o}, 8'h00);
    for (int i = 0; i < 128; i++) u_frbb_nvm_model.mem[i] = 8'hFF;
    acc(1, frbb_pkg::SEARCH_OFS, 8'h01); // after erase
    wait_busy();
    acc(1, frbb_pkg::CONTROL_OFS, 8'h00);
    step();
    wait_busy();
    chk(u_frbb_nvm_model.mem[0], {2'b00, st});
    wrap_up();
  end
endmodule
bind frbb_recorder frbb_recorder_properties #(.SLOTS(SLOTS),
  .REC_BYTES(REC_BYTES)) u_frbb_recorder_properties (.mclk_i, .rst_b_i,
  .reg_req_i, .reg_rdata_o, .nvm_ack_i, .nvm_req_o, .busy_o);
